// ==== iwc_consts.svh ====
// Constants for the wiper command I2C slave and its bus master.
// Assumes a 50 MHz core clock shared by both ends.
`ifndef IWC_CONSTS_SVH
`define IWC_CONSTS_SVH

// Fixed slave addresses, default and alternate part variant.
`define IWC_ADDR_DEFAULT 7'h2E
`define IWC_ADDR_ALT     7'h3E
// General Call address, never acknowledged.
`define IWC_GCALL_ADDR   7'h00
// Wiper value loaded at reset, mid-scale.
`define IWC_WIPER_RESET  7'h3F
// Only command code that reaches the wiper register.
`define IWC_VALID_CMD    8'h00
// Read data returned for a non-zero command code (line left released).
`define IWC_BAD_CMD_DATA 8'hFF
// Direction bit values in the control byte.
`define IWC_DIR_WRITE    1'b0
`define IWC_DIR_READ     1'b1
// Bus timing: core clock period and least quarter of an SCL period.
`define IWC_CLK_NS       20
`define IWC_QTR_NS       625
`define IWC_QTR_CYC      ((`IWC_QTR_NS + `IWC_CLK_NS - 1) / `IWC_CLK_NS)

`endif

// ==== iwc_pkg.sv ====
// Types shared by the wiper command slave and its bus master.
// Assumes iwc_consts.svh provides the numeric constants.
package iwc_pkg;

    // Slave protocol states.
    typedef enum logic [3:0] {
        IWC_S_IDLE,
        IWC_S_ADDR,
        IWC_S_ADDR_ACK,
        IWC_S_CMD,
        IWC_S_CMD_ACK,
        IWC_S_WDATA,
        IWC_S_WDATA_ACK,
        IWC_S_RDATA,
        IWC_S_RACK
    } iwc_sstate_t;

    // Bus operations performed by the master, one per step.
    typedef enum logic [1:0] {
        IWC_OP_START,
        IWC_OP_BYTE,
        IWC_OP_RBYTE,
        IWC_OP_STOP
    } iwc_op_t;

    // Transaction kinds requested from the master user port.
    typedef enum logic [1:0] {
        IWC_K_WRITE,
        IWC_K_READ,
        IWC_K_RESET
    } iwc_kind_t;

endpackage

// ==== iwc_bus_if.sv ====
// Two-wire bus joining the wiper slave and the bus master.
// Assumes open-drain wires with pull-ups; levels resolve from the enables.
`timescale 1ns/100ps
interface iwc_bus_if;
    // Master drives of the clock and data wires.
    logic m_scl_out;
    logic m_scl_oe;
    logic m_sda_out;
    logic m_sda_oe;
    // Slave drive of the data wire; the slave never drives the clock.
    logic s_sda_out;
    logic s_sda_oe;
    // Resolved wire levels, high unless someone pulls low.
    logic scl;
    logic sda;

    assign scl = !(m_scl_oe && !m_scl_out);
    assign sda = !((m_sda_oe && !m_sda_out) || (s_sda_oe && !s_sda_out));

    modport dev (input scl, input sda, output s_sda_out, output s_sda_oe);
    modport mst (input scl, input sda, output m_scl_out, output m_scl_oe,
                 output m_sda_out, output m_sda_oe);
endinterface

// ==== iwc_slave.sv ====
// Wiper command I2C slave: one 7-bit volatile wiper behind a command code.
// Assumes SCL and SDA arrive asynchronously and are much slower than clk.
`timescale 1ns/100ps
`include "iwc_consts.svh"
module iwc_slave
    import iwc_pkg::*;
#(
    parameter bit ALT_ADDR = 1'b0
) (
    // Clock and reset.
    input  wire logic       core_clk,
    input  wire logic       rstn,
    // Bus pins.
    iwc_bus_if.dev          bus,
    // Wiper value and its update strobe.
    output logic      [6:0] wiper,
    output logic            wiper_wr,
    // Interface state for observation.
    output logic            active
);

    // Address is a build constant; no pin can change it.
    localparam logic [6:0] SLV_ADDR = ALT_ADDR ? `IWC_ADDR_ALT
                                               : `IWC_ADDR_DEFAULT;

    logic        scl_m;
    logic        scl_s;
    logic        scl_d;
    logic        sda_m;
    logic        sda_s;
    logic        sda_d;
    iwc_sstate_t state;
    iwc_sstate_t next_state;
    logic [7:0]  rx;
    logic [7:0]  tx;
    logic [2:0]  bitcnt;
    logic        byte_full;
    logic        dir_rd;
    logic        cmd_ok;
    logic        cmd_seen;

    // Two-flop synchronisers, then one more stage for edge detection.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_m <= bus.scl;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= bus.sda;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end

    // Bus events decoded from the synchronised wires.
    wire scl_rise = scl_s && !scl_d;
    wire scl_fall = !scl_s && scl_d;
    wire bus_start = scl_s && scl_d && sda_d && !sda_s;
    wire bus_stop  = scl_s && scl_d && !sda_d && sda_s;

    // Received byte decoding.
    wire [6:0] rx_addr    = rx[7:1];
    wire       rx_dir     = rx[0];
    wire       addr_hit   = (rx_addr == SLV_ADDR);
    wire       gcall      = (rx_addr == `IWC_GCALL_ADDR);
    wire       rd_allowed = cmd_seen || (rx_dir == `IWC_DIR_WRITE);
    wire       addr_take  = addr_hit && !gcall && rd_allowed;
    wire [7:0] rd_byte    = cmd_ok ? {1'b0, wiper}
                                   : `IWC_BAD_CMD_DATA;
    wire       rxing      = (state == IWC_S_ADDR) || (state == IWC_S_CMD)
                            || (state == IWC_S_WDATA);
    wire       in_ack     = (state == IWC_S_ADDR_ACK)
                            || (state == IWC_S_CMD_ACK)
                            || (state == IWC_S_WDATA_ACK);
    wire       commit     = scl_fall && byte_full && (state == IWC_S_WDATA)
                            && cmd_ok;

    // Next-state decode; START and STOP take precedence over bit events.
    always_comb begin
        next_state = state;
        if (bus_start) begin
            next_state = IWC_S_ADDR;
        end else if (bus_stop) begin
            next_state = IWC_S_IDLE;
        end else if (scl_fall) begin
            case (state)
                IWC_S_ADDR: begin
                    if (byte_full) begin
                        // General Call and foreign addresses fall off.
                        next_state = addr_take ? IWC_S_ADDR_ACK
                                               : IWC_S_IDLE;
                    end
                end
                IWC_S_CMD: begin
                    if (byte_full) begin
                        next_state = IWC_S_CMD_ACK;
                    end
                end
                IWC_S_WDATA: begin
                    if (byte_full) begin
                        next_state = IWC_S_WDATA_ACK;
                    end
                end
                IWC_S_ADDR_ACK: begin
                    next_state = dir_rd ? IWC_S_RDATA : IWC_S_CMD;
                end
                IWC_S_CMD_ACK: begin
                    next_state = IWC_S_WDATA;
                end
                IWC_S_WDATA_ACK: begin
                    next_state = IWC_S_WDATA;
                end
                IWC_S_RDATA: begin
                    if (bitcnt == 3'h7) begin
                        next_state = IWC_S_RACK;
                    end
                end
                IWC_S_RACK: begin
                    next_state = IWC_S_RDATA;
                end
                IWC_S_IDLE: begin
                    next_state = IWC_S_IDLE;
                end
                default: begin
                    next_state = IWC_S_IDLE;
                end
            endcase
        end else if (scl_rise && (state == IWC_S_RACK) && sda_s) begin
            // A master that does not acknowledge ends the read.
            next_state = IWC_S_IDLE;
        end
    end

    // State register.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state <= IWC_S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Receive shifter and bit counter; SDA is sampled on SCL rise.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rx        <= 8'h00;
            bitcnt    <= 3'h0;
            byte_full <= 1'b0;
        end else if (bus_start || bus_stop || (scl_fall && in_ack)) begin
            bitcnt    <= 3'h0;
            byte_full <= 1'b0;
        end else if (scl_rise && rxing) begin
            rx        <= {rx[6:0], sda_s};
            bitcnt    <= bitcnt + 3'h1;
            byte_full <= (bitcnt == 3'h7);
        end else if (scl_fall && byte_full) begin
            byte_full <= 1'b0;
        end else if (scl_fall && (state == IWC_S_RDATA)) begin
            bitcnt    <= bitcnt + 3'h1;
        end else if (scl_fall && (state == IWC_S_RACK)) begin
            bitcnt    <= 3'h0;
        end
    end

    // Direction and command-code qualification for the transaction.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dir_rd   <= 1'b0;
            cmd_ok   <= 1'b0;
            cmd_seen <= 1'b0;
        end else if (bus_stop) begin
            cmd_seen <= 1'b0;
        end else if (scl_fall && byte_full) begin
            if (state == IWC_S_ADDR) begin
                dir_rd <= rx_dir;
            end else if (state == IWC_S_CMD) begin
                cmd_ok   <= (rx == `IWC_VALID_CMD);
                cmd_seen <= 1'b1;
            end
        end
    end

    // Transmit shifter, loaded as the read byte starts and after each ACK.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tx <= 8'hFF;
        end else if (scl_fall && (next_state == IWC_S_RDATA)
                     && (state != IWC_S_RDATA)) begin
            tx <= rd_byte;
        end else if (scl_fall && (state == IWC_S_RDATA)) begin
            tx <= {tx[6:0], 1'b1};
        end
    end

    // Wiper register; only reset and committed data bytes touch it.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wiper    <= `IWC_WIPER_RESET;
            wiper_wr <= 1'b0;
        end else begin
            wiper_wr <= commit;
            if (commit) begin
                wiper <= rx[6:0];
            end
        end
    end

    // SDA is pulled low only in an ACK slot or for a zero read bit.
    assign bus.s_sda_out = 1'b0;
    assign bus.s_sda_oe  = in_ack
                           || ((state == IWC_S_RDATA) && !tx[7]);
    // SCL is an input only; no stretching is ever applied.
    assign active = (state != IWC_S_IDLE);

endmodule // iwc_slave

// ==== iwc_master.sv ====
// Bus master for the wiper slave: write, read and interface recovery.
// Assumes one transaction at a time from the user port and no stretching.
`timescale 1ns/100ps
`include "iwc_consts.svh"
module iwc_master
    import iwc_pkg::*;
#(
    parameter int QTR_CYC = `IWC_QTR_CYC
) (
    // Clock and reset.
    input  wire logic       core_clk,
    input  wire logic       rstn,
    // Bus pins.
    iwc_bus_if.mst          bus,
    // Transaction request.
    input  wire logic       req,
    input  wire iwc_kind_t  kind,
    input  wire logic [6:0] addr,
    input  wire logic [7:0] cmd,
    input  wire logic [7:0] wdata,
    // Transaction status and result.
    output logic            busy,
    output logic            done,
    output logic            nack_err,
    output logic      [7:0] rdata
);

    logic        sda_m;
    logic        sda_s;
    logic [15:0] divcnt;
    logic [1:0]  phase;
    logic [3:0]  bitidx;
    logic [2:0]  step;
    logic [8:0]  txsh;
    logic [8:0]  rxsh;
    iwc_kind_t   kind_q;
    logic [6:0]  addr_q;
    logic [7:0]  cmd_q;
    logic [7:0]  wdata_q;
    iwc_op_t     op;
    logic [7:0]  op_byte;
    logic [2:0]  last_step;

    // Step tables for each transaction kind.
    always_comb begin
        op        = IWC_OP_STOP;
        op_byte   = 8'hFF;
        last_step = 3'h4;
        case (kind_q)
            IWC_K_WRITE: begin
                last_step = 3'h4;
                case (step)
                    3'h0: op = IWC_OP_START;
                    3'h1: begin
                        op      = IWC_OP_BYTE;
                        op_byte = {addr_q, `IWC_DIR_WRITE};
                    end
                    3'h2: begin
                        op      = IWC_OP_BYTE;
                        op_byte = cmd_q;
                    end
                    3'h3: begin
                        op      = IWC_OP_BYTE;
                        op_byte = wdata_q;
                    end
                    default: op = IWC_OP_STOP;
                endcase
            end
            IWC_K_READ: begin
                last_step = 3'h6;
                case (step)
                    3'h0: op = IWC_OP_START;
                    3'h1: begin
                        op      = IWC_OP_BYTE;
                        op_byte = {addr_q, `IWC_DIR_WRITE};
                    end
                    3'h2: begin
                        op      = IWC_OP_BYTE;
                        op_byte = cmd_q;
                    end
                    3'h3: op = IWC_OP_START;
                    3'h4: begin
                        op      = IWC_OP_BYTE;
                        op_byte = {addr_q, `IWC_DIR_READ};
                    end
                    3'h5: op = IWC_OP_RBYTE;
                    default: op = IWC_OP_STOP;
                endcase
            end
            default: begin
                last_step = 3'h3;
                case (step)
                    3'h0: op = IWC_OP_START;
                    3'h1: op = IWC_OP_RBYTE;
                    3'h2: op = IWC_OP_START;
                    default: op = IWC_OP_STOP;
                endcase
            end
        endcase
    end

    // Quarter-bit tick and end-of-operation decode.
    wire tick     = busy && (divcnt == 16'(QTR_CYC - 1));
    wire is_byte  = (op == IWC_OP_BYTE) || (op == IWC_OP_RBYTE);
    wire byte_end = is_byte && (phase == 2'h3) && (bitidx == 4'h8);
    wire cond_end = ((op == IWC_OP_START) && (phase == 2'h3))
                    || ((op == IWC_OP_STOP) && (phase == 2'h2));
    wire acked    = !rxsh[0];
    wire ack_fail = byte_end && (op == IWC_OP_BYTE) && !acked;

    // Data line synchroniser.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sda_m <= 1'b1;
            sda_s <= 1'b1;
        end else begin
            sda_m <= bus.sda;
            sda_s <= sda_m;
        end
    end

    // Sequencer: one operation per step, four phases per bit.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            busy         <= 1'b0;
            done         <= 1'b0;
            nack_err     <= 1'b0;
            rdata        <= 8'h00;
            divcnt       <= 16'h0000;
            phase        <= 2'h0;
            bitidx       <= 4'h0;
            step         <= 3'h0;
            txsh         <= 9'h1FF;
            rxsh         <= 9'h1FF;
            kind_q       <= IWC_K_WRITE;
            addr_q       <= 7'h00;
            cmd_q        <= 8'h00;
            wdata_q      <= 8'h00;
            bus.m_scl_oe <= 1'b0;
            bus.m_sda_oe <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!busy) begin
                if (req) begin
                    busy     <= 1'b1;
                    nack_err <= 1'b0;
                    kind_q   <= kind;
                    addr_q   <= addr;
                    cmd_q    <= cmd;
                    wdata_q  <= wdata;
                    step     <= 3'h0;
                    phase    <= 2'h0;
                    bitidx   <= 4'h0;
                    divcnt   <= 16'h0000;
                end
            end else if (!tick) begin
                divcnt <= divcnt + 16'h0001;
            end else begin
                divcnt <= 16'h0000;
                phase  <= phase + 2'h1;
                case (phase)
                    2'h0: begin
                        bus.m_scl_oe <= 1'b1;
                        if (op == IWC_OP_START) begin
                            bus.m_sda_oe <= 1'b0;
                        end else if (op == IWC_OP_STOP) begin
                            bus.m_sda_oe <= 1'b1;
                        end else begin
                            bus.m_sda_oe <= (bitidx == 4'h0) ? !op_byte[7]
                                                             : !txsh[8];
                            if (bitidx == 4'h0) begin
                                txsh <= {op_byte, 1'b1};
                            end
                        end
                    end
                    2'h1: begin
                        bus.m_scl_oe <= 1'b0;
                    end
                    2'h2: begin
                        if (op == IWC_OP_START) begin
                            bus.m_sda_oe <= 1'b1;
                        end else if (op == IWC_OP_STOP) begin
                            bus.m_sda_oe <= 1'b0;
                            busy         <= 1'b0;
                            done         <= 1'b1;
                        end else begin
                            rxsh <= {rxsh[7:0], sda_s};
                        end
                    end
                    default: begin
                        bus.m_scl_oe <= 1'b1;
                        if (is_byte) begin
                            txsh   <= {txsh[7:0], 1'b1};
                            bitidx <= bitidx + 4'h1;
                        end
                    end
                endcase
                if (byte_end || cond_end) begin
                    phase  <= 2'h0;
                    bitidx <= 4'h0;
                    step   <= ack_fail ? last_step : step + 3'h1;
                    if (ack_fail && (kind_q != IWC_K_RESET)) begin
                        nack_err <= 1'b1;
                    end
                    if (byte_end && (op == IWC_OP_RBYTE)) begin
                        rdata <= rxsh[8:1];
                    end
                end
            end
        end
    end

    // Open-drain drives: value is always low, enables decide.
    assign bus.m_scl_out = 1'b0;
    assign bus.m_sda_out = 1'b0;

endmodule // iwc_master

// ==== iwc_bus_properties.sv ====
// Concurrent checks on the bus between the wiper slave and its master.
// Assumes one core clock and the resolved wire levels of the bus interface.
`timescale 1ns/100ps
`include "iwc_consts.svh"
module iwc_bus_checker (
    // Clock and reset.
    input wire logic       core_clk,
    input wire logic       rstn,
    // Bus wires and drives.
    input wire logic       scl,
    input wire logic       sda,
    input wire logic       m_scl_oe,
    input wire logic       s_sda_oe,
    // Slave outputs.
    input wire logic [6:0] wiper,
    input wire logic       wiper_wr,
    input wire logic       active
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // Bus conditions are SDA edges while SCL is high.
    sequence start_s; scl && $fell(sda); endsequence
    sequence stop_s;  scl && $rose(sda); endsequence

    // Wiper value and its update strobe.
    AST_RESET_VALUE: assert property (
        $rose(rstn) |-> wiper == `IWC_WIPER_RESET)
        else $error("wiper not at mid-scale after reset");
    AST_WIPER_CAUSE: assert property (!$stable(wiper) |-> wiper_wr)
        else $error("wiper changed without a commit");
    AST_COMMIT_IN_ACK: assert property (wiper_wr |-> s_sda_oe && !scl)
        else $error("commit outside the acknowledge slot");
    AST_WR_PULSE: assert property (wiper_wr |=> !wiper_wr)
        else $error("commit strobe longer than one cycle");
    // Slave drive of the data and clock wires, and its return to idle.
    AST_IDLE_QUIET: assert property (!active |-> !s_sda_oe)
        else $error("idle slave drives the data wire");
    AST_STOP_IDLE: assert property (stop_s |-> ##[1:8] !active)
        else $error("slave not idle after a stop");
    AST_START_QUIET: assert property (start_s |=> !s_sda_oe [*8])
        else $error("slave drives the data wire after a start");
    AST_SLAVE_EDGE: assert property (
        $changed(s_sda_oe) |-> !scl)
        else $error("slave changed the data wire while the clock was high");
    AST_ACK_HOLD: assert property (
        $rose(s_sda_oe) |-> s_sda_oe [*4])
        else $error("slave drive too short");
    AST_NO_STRETCH: assert property (!scl |-> m_scl_oe)
        else $error("clock wire held low by the slave");
endmodule // iwc_bus_checker

// ==== test_iwc_slave.sv ====
// Self-checking bench: the master drives the slave across the bus.
// Assumes the design files and the constants header are compiled first.
`timescale 1ns/100ps
`include "iwc_consts.svh"
module test_i2c_wiper_cmd_slave
    import iwc_pkg::*;
;
    // Clock, reset and the design's user-side signals.
    logic       core_clk = 1'b0;
    logic       rstn     = 1'b0;
    logic       req      = 1'b0;
    iwc_kind_t  kind     = IWC_K_WRITE;
    logic [6:0] addr     = 7'h00;
    logic [7:0] cmd      = 8'h00;
    logic [7:0] wdata    = 8'h00;
    logic       busy, done, nack_err, wiper_wr, active;
    logic [7:0] rdata;
    logic [6:0] wiper;
    // Expected results and bench bookkeeping.
    logic [6:0] exp_w[$];
    logic [9:0] exp_r[$];
    logic [6:0] model_w = `IWC_WIPER_RESET;
    logic [7:0] d;
    logic [9:0] e_r;
    int         bad_count = 0;
    int         check_count = 0;
    int         cycles = 0;
    logic [6:0] bad_addr[3] = '{`IWC_ADDR_ALT, `IWC_GCALL_ADDR, 7'h2F};

    iwc_bus_if bus_if ();
    iwc_slave u_iwc_slave (.core_clk, .rstn, .bus(bus_if), .wiper, .wiper_wr,
                           .active);
    iwc_master #(.QTR_CYC(4)) u_iwc_master (.core_clk, .rstn, .bus(bus_if),
        .req, .kind, .addr, .cmd, .wdata, .busy, .done, .nack_err, .rdata);
    iwc_bus_checker u_chk (.core_clk, .rstn, .scl(bus_if.scl),
        .sda(bus_if.sda), .m_scl_oe(bus_if.m_scl_oe),
        .s_sda_oe(bus_if.s_sda_oe), .wiper, .wiper_wr, .active);

    // Clock of 20 ns period.
    always #10 core_clk = ~core_clk;

    // Compare tasks, one per kind of result.
    task automatic cmp_w(input logic [6:0] got, input logic [6:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_r(input logic [8:0] got, input logic [8:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Closing report and verdict.
    task automatic stop_test();
        if (exp_w.size() + exp_r.size() != 0) bad_count++;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Monitor: each commit or completion takes the oldest note.
    always @(posedge core_clk) begin
        if (wiper_wr === 1'b1) begin
            if (exp_w.size() == 0) cmp_w(wiper, 7'hXX);
            else cmp_w(wiper, exp_w.pop_front());
        end
        if (done === 1'b1) begin
            e_r = (exp_r.size() == 0) ? 10'h3XX : exp_r.pop_front();
            if (e_r[9]) cmp_r({nack_err, rdata}, e_r[8:0]);
            else cmp_r({nack_err, 8'h00}, {e_r[8], 8'h00});
        end
    end

    // Hang guard sized well above the planned traffic.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            stop_test();
        end
    end

    // One request on the master's user port, until its completion pulse.
    task automatic go(input iwc_kind_t k, input logic [6:0] a,
                      input logic [7:0] c, input logic [7:0] v);
        kind = k;
        addr = a;
        cmd = c;
        wdata = v;
        req = 1'b1;
        @(posedge core_clk);
        #1 req = 1'b0;
        while (done !== 1'b1) @(posedge core_clk);
        #1;
    endtask
    // Write: only the own address with command zero commits seven bits.
    task automatic wr(input logic [6:0] a, input logic [7:0] c,
                      input logic [7:0] v);
        if (a == `IWC_ADDR_DEFAULT && c == `IWC_VALID_CMD) begin
            model_w = v[6:0];
            exp_w.push_back(v[6:0]);
        end
        exp_r.push_back({1'b0, a != `IWC_ADDR_DEFAULT, 8'h00});
        go(IWC_K_WRITE, a, c, v);
    endtask
    // Read: zero MSB plus wiper, all ones for a non-zero command.
    task automatic rd(input logic [6:0] a, input logic [7:0] c);
        if (a != `IWC_ADDR_DEFAULT) exp_r.push_back(10'h100);
        else if (c == `IWC_VALID_CMD) exp_r.push_back({2'b10, 1'b0, model_w});
        else exp_r.push_back({2'b10, `IWC_BAD_CMD_DATA});
        go(IWC_K_READ, a, c, 8'h00);
    endtask

    // Main sequence.
    initial begin
        void'($urandom(32'h8707));
        repeat (3) @(posedge core_clk);
        #1 rstn = 1'b1;
        rd(`IWC_ADDR_DEFAULT, 8'h00);
        $display("test reset value done");
        for (int i = 0; i < 6; i++) begin
            d = 8'($urandom);
            d[7] = i[0];
            wr(`IWC_ADDR_DEFAULT, 8'h00, d);
            rd(`IWC_ADDR_DEFAULT, 8'h00);
        end
        $display("test write and read back done");
        wr(`IWC_ADDR_DEFAULT, 8'($urandom) | 8'h01, 8'($urandom));
        rd(`IWC_ADDR_DEFAULT, 8'h00);
        rd(`IWC_ADDR_DEFAULT, 8'h5A);
        $display("test command code done");
        foreach (bad_addr[i]) begin
            wr(bad_addr[i], 8'h00, 8'($urandom));
            rd(bad_addr[i], 8'h00);
            wr(`IWC_ADDR_DEFAULT, 8'h00, 8'($urandom));
        end
        $display("test address match done");
        exp_r.push_back(10'h000);
        go(IWC_K_RESET, 7'h00, 8'h00, 8'h00);
        rd(`IWC_ADDR_DEFAULT, 8'h00);
        wr(`IWC_ADDR_DEFAULT, 8'h00, 8'h7F);
        rd(`IWC_ADDR_DEFAULT, 8'h00);
        $display("test interface reset done");
        repeat (4) @(posedge core_clk);
        stop_test();
    end
endmodule // test_i2c_wiper_cmd_slave
